// ### inc/mdp_pkg.sv
// Package for the mode dependent port pin block
package mdp_pkg;

   // =====================================================================
   // Operating modes, coded as {mode_select_b, mode_select_a}
   typedef enum logic [1:0] {
      MDP_BOOT   = 2'b00,
      MDP_SINGLE = 2'b01,
      MDP_TEST   = 2'b10,
      MDP_EXPAND = 2'b11
   } mdp_mode_e;

   // =====================================================================
   // Register indexes on the plain register port
   localparam logic [3:0] ADDR_DATA_A = 4'h0;
   localparam logic [3:0] ADDR_DIRA  = 4'h1;
   localparam logic [3:0] ADDR_DATA_B = 4'h2;
   localparam logic [3:0] ADDR_DIRB  = 4'h3;
   localparam logic [3:0] ADDR_DATA_C = 4'h4;
   localparam logic [3:0] ADDR_DIRC  = 4'h5;
   localparam logic [3:0] ADDR_PORTF = 4'h6;
   localparam logic [3:0] ADDR_DIRF  = 4'h7;
   localparam logic [3:0] ADDR_PORTG = 4'h8;
   localparam logic [3:0] ADDR_DIRG  = 4'h9;
   localparam logic [3:0] ADDR_PORTE = 4'ha;
   localparam logic [3:0] ADDR_OPTIONS = 4'hb;
   localparam logic [3:0] ADDR_MODE  = 4'hc;

   // =====================================================================
   // Option register fields and reset values
   localparam int         OPT_DRVHI_BIT  = 0;
   localparam int         OPT_ODRAIN_BIT = 1;
   localparam logic [7:0] RST_DATA       = 8'h00;
   localparam logic [7:0] RST_DIR        = 8'h00;
   localparam logic [7:0] RST_OPTIONS    = 8'h00;
   localparam int         RW_PIN_BIT     = 7;

   // =====================================================================
   // Register port and expansion bus carriers
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } mdp_reg_s;

   typedef struct packed {
      logic [15:0] addr;
      logic [7:0]  wdata;
      logic        read;
      logic        valid;
   } mdp_bus_s;

endpackage : mdp_pkg

// ### src/mdp_port_pins.sv
// Mode dependent parallel port pins with expansion bus multiplexing
//
// Our own choices: the address map and the plain strobed port.
`timescale 1ns/1ps
// What this block does
// - During reset the two mode inputs choose one of four modes
// - Instruction strobe goes low in the cycle after the opcode fetch cycle of each opcode
// - Strobe only pulls low; with drive-high option it drives high for one cycle after
// - In expanded and test modes direction pin is high during reads
// - In single chip and bootstrap the direction pin is port G bit 7
// - Port B carries high address in expanded and test modes, else general I/O
// - Port C is the data bus in expanded and test modes, else general I/O
// - Port data reads: inputs give pin level, outputs give latch value, timer-owned port A bits the compare value
// - Writes to B, C, G bit 7 latch; pins driven only as outputs in chip modes
// - Port A writes leave pins under output compare unchanged
// - Port A resets to inputs; direction bits rule when timer is off
// - Port A bits share timer capture, compare and accumulator functions
// - Out of reset port C is input or data bus per mode
// - Port C open-drain option disables high drive; one floats the pin
// - Port C open-drain option works only in single chip mode
// - Ports A B C F G bidirectional; port E input only
// - Ports B C F and G bit 7 are general I/O only in chip modes
// - At reset data registers are cleared and inputs are high-impedance
// - Port F carries low address in expanded and test modes, else general I/O
module mdp_port_pins
   import mdp_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        rstn,
   input  wire logic        modeSelectA,
   input  wire logic        modeSelectB,
   input  wire mdp_reg_s    regReq,
   output logic [7:0]       regRdata,
   input  wire mdp_bus_s    extBus,
   output logic [7:0]       extRdata,
   input  wire logic        opcodeFetch,
   input  wire logic [7:0]  timerOut,
   input  wire logic [7:0]  timerOutEn,
   output logic [7:0]       timerIn,
   input  wire logic [7:0]  portAIn,
   output logic [7:0]       portAOut,
   output logic [7:0]       portAOe,
   input  wire logic [7:0]  portBIn,
   output logic [7:0]       portBOut,
   output logic [7:0]       portBOe,
   input  wire logic [7:0]  portCIn,
   output logic [7:0]       portCOut,
   output logic [7:0]       portCOe,
   input  wire logic [7:0]  portEIn,
   input  wire logic [7:0]  portFIn,
   output logic [7:0]       portFOut,
   output logic [7:0]       portFOe,
   input  wire logic [7:0]  portGIn,
   output logic [7:0]       portGOut,
   output logic [7:0]       portGOe,
   output logic             strobeOut,
   output logic             strobeOe,
   output logic [1:0]       modeOut
);

   // =====================================================================
   // Mode capture
   mdp_mode_e  mode_r;
   logic       inReset_r;
   logic [7:0] dataA_r, dataB_r, dataC_r, dataF_r, dataG_r;
   logic [7:0] dirA_r, dirB_r, dirC_r, dirF_r, dirG_r;
   logic [7:0] options_r;
   logic       strobeHi_r;
   logic       chipMode;
   logic       busMode;
   logic       wrA, wrB, wrC, wrF, wrG;
   logic [7:0] regRdata_nxt;
   logic [7:0] aOut_nxt, aOe_nxt;
   logic [7:0] bOut_nxt, bOe_nxt;
   logic [7:0] cOut_nxt, cOe_nxt;
   logic [7:0] fOut_nxt, fOe_nxt;
   logic [7:0] gOut_nxt, gOe_nxt;

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         inReset_r <= 1'b1;
      end else begin
         inReset_r <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         mode_r <= MDP_SINGLE;
      end else if (inReset_r) begin
         mode_r <= mdp_mode_e'({modeSelectB, modeSelectA});
      end
   end

   assign chipMode = (mode_r == MDP_SINGLE) || (mode_r == MDP_BOOT);
   assign busMode  = !chipMode;

   // =====================================================================
   // Register writes
   assign wrA = regReq.wr && (regReq.addr == ADDR_DATA_A);
   assign wrB = regReq.wr && (regReq.addr == ADDR_DATA_B);
   assign wrC = regReq.wr && (regReq.addr == ADDR_DATA_C);
   assign wrF = regReq.wr && (regReq.addr == ADDR_PORTF);
   assign wrG = regReq.wr && (regReq.addr == ADDR_PORTG);

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         dataA_r <= RST_DATA;
         dataB_r <= RST_DATA;
         dataC_r <= RST_DATA;
         dataF_r <= RST_DATA;
         dataG_r <= RST_DATA;
      end else begin
         if (wrA) dataA_r <= regReq.wdata;
         if (wrB) dataB_r <= regReq.wdata;
         if (wrC) dataC_r <= regReq.wdata;
         if (wrF) dataF_r <= regReq.wdata;
         if (wrG) dataG_r <= regReq.wdata;
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         dirA_r <= RST_DIR;
         dirB_r <= RST_DIR;
         dirC_r <= RST_DIR;
         dirF_r <= RST_DIR;
         dirG_r <= RST_DIR;
         options_r <= RST_OPTIONS;
      end else if (regReq.wr) begin
         case (regReq.addr)
            ADDR_DIRA: dirA_r <= regReq.wdata;
            ADDR_DIRB: dirB_r <= regReq.wdata;
            ADDR_DIRC: dirC_r <= regReq.wdata;
            ADDR_DIRF: dirF_r <= regReq.wdata;
            ADDR_DIRG: dirG_r <= regReq.wdata;
            ADDR_OPTIONS: options_r <= regReq.wdata;
            default: ;
         endcase
      end
   end

   // =====================================================================
   // Register reads, data one cycle after the strobe
   function automatic logic [7:0] portRead(input logic [7:0] dir,
                                           input logic [7:0] latch,
                                           input logic [7:0] pin);
      portRead = (dir & latch) | (~dir & pin);
   endfunction : portRead

   always_comb begin
      regRdata_nxt = 8'h00;
      case (regReq.addr)
         ADDR_DATA_A: regRdata_nxt = portRead(dirA_r | timerOutEn,
                                             aOut_nxt, portAIn);
         ADDR_DIRA:  regRdata_nxt = dirA_r;
         ADDR_DATA_B: regRdata_nxt = portRead(dirB_r, dataB_r, portBIn);
         ADDR_DIRB:  regRdata_nxt = dirB_r;
         ADDR_DATA_C: regRdata_nxt = portRead(dirC_r, dataC_r, portCIn);
         ADDR_DIRC:  regRdata_nxt = dirC_r;
         ADDR_PORTF: regRdata_nxt = portRead(dirF_r, dataF_r, portFIn);
         ADDR_DIRF:  regRdata_nxt = dirF_r;
         ADDR_PORTG: regRdata_nxt = portRead(dirG_r, dataG_r, portGIn);
         ADDR_DIRG:  regRdata_nxt = dirG_r;
         ADDR_PORTE: regRdata_nxt = portEIn;
         ADDR_OPTIONS: regRdata_nxt = options_r;
         ADDR_MODE:  regRdata_nxt = {6'h00, mode_r};
         default:    regRdata_nxt = 8'h00;
      endcase
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         regRdata <= 8'h00;
      end else if (regReq.rd) begin
         regRdata <= regRdata_nxt;
      end else begin
         regRdata <= 8'h00;
      end
   end

   // =====================================================================
   // Pin drive selection
   always_comb begin
      // Port A: timer compare owns the pin where enabled
      aOut_nxt = (timerOutEn & timerOut) | (~timerOutEn & dataA_r);
      aOe_nxt  = timerOutEn | dirA_r;
      // Port B: high address or general I/O
      bOut_nxt = busMode ? extBus.addr[15:8] : dataB_r;
      bOe_nxt  = busMode ? 8'hff : dirB_r;
      // Port F: low address or general I/O
      fOut_nxt = busMode ? extBus.addr[7:0] : dataF_r;
      fOe_nxt  = busMode ? 8'hff : dirF_r;
      // Port C: data bus, push-pull or open-drain general I/O
      if (busMode) begin
         cOut_nxt = extBus.wdata;
         cOe_nxt  = (extBus.valid && !extBus.read) ? 8'hff : 8'h00;
      end else if (options_r[OPT_ODRAIN_BIT] && mode_r == MDP_SINGLE) begin
         cOut_nxt = 8'h00;
         cOe_nxt  = dirC_r & ~dataC_r;
      end else begin
         cOut_nxt = dataC_r;
         cOe_nxt  = dirC_r;
      end
      // Port G: bit 7 is transfer direction in bus modes
      gOut_nxt = dataG_r;
      gOe_nxt  = dirG_r;
      if (busMode) begin
         gOut_nxt[RW_PIN_BIT] = !extBus.valid || extBus.read;
         gOe_nxt[RW_PIN_BIT]  = 1'b1;
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         portAOut <= 8'h00;
         portAOe  <= 8'h00;
         portBOut <= 8'h00;
         portBOe  <= 8'h00;
         portCOut <= 8'h00;
         portCOe  <= 8'h00;
         portFOut <= 8'h00;
         portFOe  <= 8'h00;
         portGOut <= 8'h00;
         portGOe  <= 8'h00;
         timerIn  <= 8'h00;
         extRdata <= 8'h00;
         modeOut  <= 2'b00;
      end else begin
         portAOut <= aOut_nxt;
         portAOe  <= aOe_nxt;
         portBOut <= bOut_nxt;
         portBOe  <= bOe_nxt;
         portCOut <= cOut_nxt;
         portCOe  <= cOe_nxt;
         portFOut <= fOut_nxt;
         portFOe  <= fOe_nxt;
         portGOut <= gOut_nxt;
         portGOe  <= gOe_nxt;
         timerIn  <= portAIn;
         extRdata <= portCIn;
         modeOut  <= mode_r;
      end
   end

   // =====================================================================
   // Instruction start strobe, open drain with optional high kick
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         strobeOut  <= 1'b0;
         strobeOe   <= 1'b0;
         strobeHi_r <= 1'b0;
      end else if (inReset_r) begin
         strobeOut  <= 1'b0;
         strobeOe   <= 1'b0;
         strobeHi_r <= 1'b0;
      end else if (opcodeFetch) begin
         strobeOut  <= 1'b0;
         strobeOe   <= 1'b1;
         strobeHi_r <= 1'b1;
      end else if (strobeHi_r && options_r[OPT_DRVHI_BIT]) begin
         strobeOut  <= 1'b1;
         strobeOe   <= 1'b1;
         strobeHi_r <= 1'b0;
      end else begin
         strobeOut  <= 1'b0;
         strobeOe   <= 1'b0;
         strobeHi_r <= 1'b0;
      end
   end

endmodule : mdp_port_pins

// ### tb/mdp_ext_mem.sv
// Expansion bus memory on the far side of the port pins
`timescale 1ns/1ps
module mdp_ext_mem (
   input  wire logic        clk_sys,
   input  wire logic        busMode,
   input  wire logic [15:0] addr,
   input  wire logic [7:0]  dataOut,
   input  wire logic [7:0]  dataOe,
   input  wire logic        rwLine,
   output logic [7:0]       rdData,
   output logic             rdEn
);
   logic [7:0] mem [256];
   // Store a fully driven write cycle
   always_ff @(posedge clk_sys) begin
      if (busMode && !rwLine && dataOe == 8'hff) begin
         mem[addr[7:0]] <= dataOut;
      end
   end
   // Drive data only while the direction line says read
   assign rdEn   = busMode && rwLine;
   assign rdData = mem[addr[7:0]];
endmodule : mdp_ext_mem

// ### tb/mdp_port_pins_chk.sv
// Assertion checker for the port pins block
`timescale 1ns/1ps
module mdp_port_pins_chk
   import mdp_pkg::*;
(
   input wire logic       clk_sys,
   input wire logic       rstn,
   input wire mdp_reg_s   regReq,
   input wire logic [7:0] regRdata,
   input wire mdp_bus_s   extBus,
   input wire logic       opcodeFetch,
   input wire logic [7:0] timerOut,
   input wire logic [7:0] timerOutEn,
   input wire logic [7:0] portAOut,
   input wire logic [7:0] portBOut,
   input wire logic [7:0] portBOe,
   input wire logic [7:0] portCOut,
   input wire logic [7:0] portCOe,
   input wire logic [7:0] portFOut,
   input wire logic [7:0] portGOut,
   input wire logic [7:0] portGOe,
   input wire logic       strobeOut,
   input wire logic       strobeOe,
   input wire logic [1:0] modeOut
);
   // =====================================================================
   // Pin and register port properties
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   sequence lowPulse;
      strobeOe && !strobeOut;
   endsequence
   mode_hold_a:
      assert property ($past(rstn, 3) |-> $stable(modeOut))
      else $error("mode changed");
   strobe_low_a:
      assert property ($past(rstn, 3) && opcodeFetch |=> lowPulse)
      else $error("strobe not low");
   strobe_high_a:
      assert property (strobeOe && strobeOut |-> $past(strobeOe)
         && !$past(strobeOut) && !$past(opcodeFetch))
      else $error("strobe high misplaced");
   rw_read_a:
      assert property ($past(rstn, 3) && modeOut[1] && extBus.read
         |=> portGOe[7] && portGOut[7])
      else $error("direction not read");
   addr_out_a:
      assert property ($past(rstn, 3) && modeOut == MDP_EXPAND
         |=> portBOe == 8'hff && {portBOut, portFOut} == $past(extBus.addr))
      else $error("address wrong");
   data_write_a:
      assert property ($past(rstn, 3) && modeOut[1] && extBus.valid
         && !extBus.read |=> portCOe == 8'hff
         && portCOut == $past(extBus.wdata))
      else $error("write data wrong");
   data_release_a:
      assert property ($past(rstn, 3) && modeOut[1] && extBus.read
         |=> portCOe == 8'h00)
      else $error("data driven in read");
   timer_pin_a:
      assert property ($past(rstn, 3) |-> (portAOut & $past(timerOutEn))
         == ($past(timerOut) & $past(timerOutEn)))
      else $error("timer pin wrong");
   read_idle_a:
      assert property (!$past(regReq.rd) |-> regRdata == 8'h00)
      else $error("read data not idle");
endmodule : mdp_port_pins_chk
bind mdp_port_pins mdp_port_pins_chk u_chk (.*);

// ### tb/tb_top.sv
// Self-checking bench for the mode dependent port pins
`timescale 1ns/1ps
module tb_top;
   import mdp_pkg::*;
   // =====================================================================
   // Stimulus, pin levels and partner
   logic       clk_sys = 1'b0, rstn = 1'b0, opcodeFetch = 1'b0;
   logic       modeSelectA = 1'b1, modeSelectB = 1'b0;
   logic       memEn, strobeOut, strobeOe;
   mdp_reg_s   regReq = '0;
   mdp_bus_s   extBus = '0;
   logic [7:0] timerOut = '0, timerOutEn = '0, ext = 8'h3c, memData, r;
   logic [7:0] regRdata, extRdata, timerIn, portEIn, portAIn, portAOut;
   logic [7:0] portAOe, portBIn, portBOut, portBOe, portCIn, portCOut;
   logic [7:0] portCOe, portFIn, portFOut, portFOe, portGIn, portGOut;
   logic [7:0] portGOe;
   logic [1:0] modeOut;
   int         n_fail = 0, check_count = 0;
   assign portEIn = ext;
   assign portAIn = portAOe & portAOut | ~portAOe & ext;
   assign portBIn = portBOe & portBOut | ~portBOe & ext;
   assign portCIn = portCOe & portCOut | ~portCOe & (memEn ? memData : ext);
   assign portFIn = portFOe & portFOut | ~portFOe & ext;
   assign portGIn = portGOe & portGOut | ~portGOe & ext;
   mdp_port_pins DUT (.*);
   mdp_ext_mem u_mem (.clk_sys, .busMode(modeOut[1]),
      .addr({portBOut, portFOut}),
      .dataOut(portCOut), .dataOe(portCOe), .rwLine(portGOut[7]),
      .rdData(memData), .rdEn(memEn));
   initial begin
      forever #25 clk_sys = ~clk_sys;
   end
   // =====================================================================
   // Shared tasks
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      check_count++;
      if (g !== e) begin
         n_fail++;
         $display("ERROR at %0t got %h expected %h", $time, g, e);
      end
   endtask : chk
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      regReq <= '{a, d, 1'b1, 1'b0};
      @(posedge clk_sys);
      regReq.wr <= 1'b0;
   endtask : wr
   task automatic rdc(input logic [3:0] a, input logic [7:0] e);
      @(posedge clk_sys);
      regReq <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge clk_sys);
      regReq.rd <= 1'b0;
      @(negedge clk_sys);
      chk(regRdata, e);
   endtask : rdc
   task automatic doReset(input logic [1:0] m);
      @(posedge clk_sys);
      {modeSelectB, modeSelectA} <= m;
      rstn <= 1'b0;
      repeat (5) @(posedge clk_sys);
      rstn <= 1'b1;
      repeat (3) @(posedge clk_sys);
      {modeSelectB, modeSelectA} <= ~m;
      repeat (2) @(negedge clk_sys);
   endtask : doReset
   function automatic logic [15:0] pinsOf(input int k);
      case (k)
         0: return {portBOe, portBOut};
         1: return {portCOe, portCOut};
         2: return {portFOe, portFOut};
         default: return {portGOe, portGOut};
      endcase
   endfunction : pinsOf
   task automatic conclude;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : conclude
   // =====================================================================
   // Scenarios
   task automatic tModes;
      for (int m = 0; m < 4; m++) begin
         doReset(2'(m));
         chk(modeOut, 8'(m));
         rdc(ADDR_MODE, 8'(m));
         chk(portCOe, 8'h00);
         chk(portBOe, m > 1 ? 8'hff : 8'h00);
         chk({portGOe[7], portGOut[7]}, m > 1 ? 8'h03 : 8'h00);
      end
   endtask : tModes
   task automatic tGpio;
      logic [15:0] p;
      logic [3:0] a;
      doReset(2'b01);
      chk(portAOe, 8'h00);
      rdc(ADDR_DIRA, 8'h00);
      rdc(4'hf, 8'h00);
      rdc(ADDR_PORTE, ext);
      for (int k = 0; k < 4; k++) begin
         a = ADDR_DATA_B + 4'(2 * k);
         wr(a + 4'h1, 8'hf0);
         wr(a, 8'ha5);
         repeat (2) @(negedge clk_sys);
         p = pinsOf(k);
         chk(p[15:8], 8'hf0);
         chk(p[7:0] & 8'hf0, 8'ha0);
         rdc(a, 8'hac);
      end
   endtask : tGpio
   task automatic tPortA;
      wr(ADDR_DIRA, 8'hff);
      timerOutEn <= 8'h0f;
      timerOut <= 8'h0a;
      wr(ADDR_DATA_A, 8'h33);
      repeat (2) @(negedge clk_sys);
      chk(portAOut, 8'h3a);
      rdc(ADDR_DATA_A, 8'h3a);
      chk(timerIn, 8'h3a);
      @(posedge clk_sys);
      timerOutEn <= 8'h00;
      wr(ADDR_DIRA, 8'h0f);
      repeat (2) @(negedge clk_sys);
      chk(portAOe, 8'h0f);
   endtask : tPortA
   task automatic tOpenDrain(input logic [1:0] m, input logic [7:0] oe);
      doReset(m);
      wr(ADDR_DIRC, 8'hff);
      wr(ADDR_DATA_C, 8'h0f);
      wr(ADDR_OPTIONS, 8'h02);
      repeat (2) @(negedge clk_sys);
      chk(portCOe, oe);
      chk(portCOut & oe, 8'h0f & oe);
   endtask : tOpenDrain
   task automatic busCyc(input logic [15:0] a, input logic [7:0] d,
                         input logic rw);
      @(posedge clk_sys);
      extBus <= '{a, d, rw, 1'b1};
      @(posedge clk_sys);
      extBus.valid <= 1'b0;
      @(negedge clk_sys);
      chk(portBOut, a[15:8]);
      chk(portFOut, a[7:0]);
      chk(portGOut[7], rw);
      if (!rw) chk(portCOut, d);
      @(negedge clk_sys);
      if (rw) chk(extRdata, d);
   endtask : busCyc
   task automatic tStrobe(input logic [7:0] opt);
      wr(ADDR_OPTIONS, opt);
      opcodeFetch <= 1'b1;
      @(posedge clk_sys);
      opcodeFetch <= 1'b0;
      @(negedge clk_sys);
      chk({strobeOe, strobeOut}, 8'h02);
      @(negedge clk_sys);
      chk({strobeOe, strobeOut}, opt[0] ? 8'h03 : 8'h00);
   endtask : tStrobe
   initial begin
      repeat (4000) @(posedge clk_sys);
      n_fail++;
      conclude;
   end
   initial begin
      tModes;
      tGpio;
      tPortA;
      tStrobe(8'h00);
      tStrobe(8'h01);
      tOpenDrain(2'b01, 8'hf0);
      tOpenDrain(2'b00, 8'hff);
      doReset(2'b11);
      wr(ADDR_DIRB, 8'hff);
      wr(ADDR_DATA_B, 8'h00);
      busCyc(16'h1234, 8'h77, 1'b0);
      busCyc(16'h1234, 8'h77, 1'b1);
      conclude;
   end
endmodule : tb_top
